// file: hw/dmabc_pkg.sv
// Shared constants, register map and state type for the DMA bus-cycle block.
package dmabc_pkg;
   localparam int DMABC_REG_W = 16;
   localparam logic [3:0] DMABC_OFS_COMMAND_WRITE_REG = 4'h0;
   localparam logic [3:0] DMABC_OFS_CTRL = 4'h1;
   localparam logic [3:0] DMABC_OFS_TIM_A = 4'h2;
   localparam logic [3:0] DMABC_OFS_TIM_B = 4'h3;
   localparam logic [3:0] DMABC_OFS_ADDR_A = 4'h4;
   localparam logic [3:0] DMABC_OFS_ADDR_B = 4'h5;
   localparam logic [3:0] DMABC_OFS_BLEN = 4'h6;
   localparam logic [3:0] DMABC_OFS_MATCH = 4'h7;
   localparam logic [3:0] DMABC_OFS_STATUS = 4'h8;
   localparam logic [3:0] DMABC_OFS_COUNT = 4'h9;
   localparam logic [7:0] DMABC_CMD_ENABLE = 8'h87;
   localparam logic [7:0] DMABC_CMD_EN_AFTER_RETURN_FROM_INTERRUPT = 8'hB7;
   localparam logic [7:0] DMABC_CMD_DISABLE = 8'h83;
   localparam logic [7:0] DMABC_CMD_LOAD = 8'hCF;
   localparam int DMABC_CTRL_MODE = 0;
   localparam int DMABC_CTRL_RDY_HI = 2;
   localparam int DMABC_CTRL_WAIT_EN = 3;
   localparam int DMABC_CTRL_VAR = 4;
   localparam int DMABC_CTRL_STOP_MATCH = 5;
   localparam int DMABC_CTRL_OP = 6;
   localparam int DMABC_CTRL_A_TO_B = 8;
   localparam int DMABC_CTRL_A_IO = 9;
   localparam int DMABC_CTRL_B_IO = 10;
   localparam int DMABC_CTRL_A_INC = 11;
   localparam int DMABC_CTRL_B_INC = 12;
   localparam int DMABC_CTRL_INT_RDY = 13;
   localparam logic [1:0] DMABC_MODE_BYTE = 2'h0;
   localparam logic [1:0] DMABC_MODE_CONT = 2'h1;
   localparam logic [1:0] DMABC_MODE_BURST = 2'h2;
   localparam int DMABC_TIM_LEN = 0;
   localparam int DMABC_TIM_E_IO_REQUEST_STROBE = 3;
   localparam int DMABC_TIM_E_MEMORY_REQUEST_STROBE = 4;
   localparam int DMABC_TIM_E_RD = 5;
   localparam int DMABC_TIM_E_WR = 6;
   localparam int DMABC_STS_OWNER = 0;
   localparam int DMABC_STS_MATCH = 1;
   localparam int DMABC_STS_EOB = 2;
   localparam int DMABC_STS_INT = 3;
   localparam logic [15:0] DMABC_CTRL_RST = 16'h0000;
   localparam logic [15:0] DMABC_TIM_RST = 16'h0003;
   localparam logic [15:0] DMABC_ADDR_RST = 16'h0000;
   localparam logic [15:0] DMABC_BLEN_RST = 16'h0000;
   localparam logic [7:0] DMABC_MATCH_RST = 8'h00;
   localparam logic [2:0] DMABC_DEF_MEM_LEN = 3'h3;
   localparam logic [2:0] DMABC_DEF_IO_LEN = 3'h4;
   localparam logic [2:0] DMABC_VAR_MIN_LEN = 3'h2;
   localparam logic [2:0] DMABC_VAR_MAX_LEN = 3'h4;
   localparam logic [2:0] DMABC_WS_T2 = 3'h2;
   localparam logic [2:0] DMABC_WS_T3 = 3'h3;
   localparam logic [2:0] DMABC_WS_NONE = 3'h0;
   localparam logic [1:0] DMABC_BAI_LOW_EDGES = 2'h2;
   typedef enum logic [2:0] {
      ST_OFF, ST_WAIT_RDY, ST_ACK, ST_READ, ST_WRITE, ST_IDLE_RDY, ST_REL
   } dmabc_state_e;
endpackage

// file: hw/dmabc_top.sv
// DMA bus-cycle engine: host register port, bus request and release, read/write strobes.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - While inactive the block is a host peripheral taking writes and giving status reads.
// - Host status, counter and address reads return data the cycle after the strobe.
// - Default timing: read data captured at the falling edge of the last state.
// - Default memory cycles last three states, I/O cycles four with one inserted wait.
// - Wait input sampled at falling edge of T2 (memory) or T3 (I/O); low adds a state, resampled.
// - Read and write port cycle lengths programmable to two, three or four states.
// - Variable mode: each strobe may end half a state early.
// - Variable mode: I/O strobe starts half a state before the other strobes.
// - Variable mode waits: memory 3/4-state at T2, I/O 4-state at T3 only.
// - Variable mode: data captured where read strobe ends, held through the write.
// - Ready sampled every rising edge; active and bus free gives bus request next edge.
// - Two consecutive low acknowledge samples, transfer starts on the next rising edge.
// - Byte mode: bus request dropped one rising edge before the byte's last cycle ends.
// - Byte mode: next request waits until request and acknowledge are both high.
// - Burst/continuous: request dropped on the edge finishing the block; last byte completes.
// - Burst: ready inactive releases the bus on the edge after the current byte.
// - Continuous: ready inactive keeps the bus and idles until ready returns.
// - Burst/continuous: stop on match releases after the next read (search) or following write.
// - Interrupt on ready never requests the bus; re-enable is B7, 87, then return.
// - Interrupt output asserted only while the block is inactive.
module dmabc_top
   import dmabc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   output logic [15:0] addr_o,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   output logic bus_oe_o,
   output logic memory_request_strobe_n_o,
   output logic io_request_strobe_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   input wire logic ready_i,
   input wire logic wait_n_i,
   output logic bus_request_out_n_o,
   output logic bus_request_out_oe_o,
   input wire logic bus_request_in_n_i,
   input wire logic bus_ack_in_n_i,
   output logic bus_ack_chain_out_n_o,
   input wire logic return_from_interrupt_i,
   output logic int_n_o
);
   dmabc_state_e state_reg;
   logic tph_reg, stretch_reg, req_reg, rdy_s_reg, match_reg, match_old_reg, eob_reg;
   logic int_pend_reg, arm_reg, en_pend_reg;
   logic [2:0] t_reg;
   logic [1:0] bai_cnt_reg;
   logic [15:0] ctrl_reg, tim_a_reg, tim_b_reg, addr_a_reg, addr_b_reg, blen_reg, count_reg;
   logic [15:0] cur_a_reg, cur_b_reg;
   logic [7:0] match_byte_reg;

   // The block's logic runs at twice the bus state rate: tph_reg low is the high half of a
   // state, so the next edge is a falling one; tph_reg high means a rising edge comes next.
   logic tick, fall, rd_st, cyc_act, owner, inactive, a_to_b, src_io, dst_io, io_now, var_md;
   logic op_xfer, op_srch, byte_md, final_cyc, last_t, cyc_end, byte_end, cap, rdy_act;
   logic last_byte, stop_now, wr_cmd, cfg_wr, go_cmd, go_return_from_interrupt;
   logic [15:0] tim_now;
   logic [2:0] len_fld, cyc_len, ws_t;
   logic [1:0] mode;
   logic [7:0] cmd;

   assign tick = ce_i && tph_reg;
   assign fall = ce_i && !tph_reg;
   assign rd_st = (state_reg == ST_READ);
   assign cyc_act = rd_st || (state_reg == ST_WRITE);
   assign owner = cyc_act || (state_reg == ST_IDLE_RDY);
   assign inactive = (state_reg == ST_OFF) || (state_reg == ST_WAIT_RDY);
   assign mode = ctrl_reg[DMABC_CTRL_MODE +: 2];
   assign byte_md = (mode == DMABC_MODE_BYTE);
   assign var_md = ctrl_reg[DMABC_CTRL_VAR];
   assign op_xfer = ctrl_reg[DMABC_CTRL_OP];
   assign op_srch = ctrl_reg[DMABC_CTRL_OP + 1];
   assign a_to_b = ctrl_reg[DMABC_CTRL_A_TO_B];
   assign src_io = a_to_b ? ctrl_reg[DMABC_CTRL_A_IO] : ctrl_reg[DMABC_CTRL_B_IO];
   assign dst_io = a_to_b ? ctrl_reg[DMABC_CTRL_B_IO] : ctrl_reg[DMABC_CTRL_A_IO];
   assign io_now = rd_st ? src_io : dst_io;
   assign tim_now = (rd_st == a_to_b) ? tim_a_reg : tim_b_reg;
   assign len_fld = tim_now[DMABC_TIM_LEN +: 3];
   assign rdy_act = (ready_i == ctrl_reg[DMABC_CTRL_RDY_HI]);

   // Cycle length: fixed in default timing, per port in variable mode.
   always_comb begin
      if (!var_md) begin
         cyc_len = io_now ? DMABC_DEF_IO_LEN : DMABC_DEF_MEM_LEN;
      end else if (len_fld < DMABC_VAR_MIN_LEN) begin
         cyc_len = DMABC_VAR_MIN_LEN;
      end else if (len_fld > DMABC_VAR_MAX_LEN) begin
         cyc_len = DMABC_VAR_MAX_LEN;
      end else begin
         cyc_len = len_fld;
      end
   end

   // State whose falling edge samples the wait input; a two-state cycle cannot stretch.
   always_comb begin
      if (!var_md) begin
         ws_t = io_now ? DMABC_WS_T3 : DMABC_WS_T2;
      end else if (io_now) begin
         ws_t = (cyc_len == DMABC_VAR_MAX_LEN) ? DMABC_WS_T3 : DMABC_WS_NONE;
      end else begin
         ws_t = (cyc_len >= DMABC_DEF_MEM_LEN) ? DMABC_WS_T2 : DMABC_WS_NONE;
      end
   end

   assign last_t = (t_reg == cyc_len);
   assign cyc_end = cyc_act && tick && last_t && !stretch_reg;
   assign final_cyc = !rd_st || !op_xfer;
   assign byte_end = cyc_end && final_cyc;
   assign last_byte = (count_reg == blen_reg);
   // Matches are known one operation late, so a search stops on the read after the match.
   assign stop_now = ctrl_reg[DMABC_CTRL_STOP_MATCH] && !byte_md &&
      (op_xfer ? match_reg : match_old_reg);

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tph_reg <= 1'b0;
      end else if (ce_i) begin
         tph_reg <= !tph_reg;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         t_reg <= 3'h1;
         stretch_reg <= 1'b0;
      end else if (ce_i) begin
         if (!cyc_act) begin
            t_reg <= 3'h1;
            stretch_reg <= 1'b0;
         end else begin
            if (!tph_reg && t_reg == ws_t && ctrl_reg[DMABC_CTRL_WAIT_EN]) begin
               stretch_reg <= !wait_n_i;
            end
            if (tph_reg) begin
               if (stretch_reg) begin
                  stretch_reg <= 1'b0;
               end else if (last_t) begin
                  t_reg <= 3'h1;
               end else begin
                  t_reg <= t_reg + 3'h1;
               end
            end
         end
      end
   end

   function automatic logic win(input logic early_start, input logic early_end);
      return cyc_act && !(t_reg == 3'h1 && !tph_reg && !early_start) &&
         !(early_end && last_t && tph_reg && !stretch_reg);
   endfunction

   assign rd_n_o = !(rd_st && win(1'b0, var_md && tim_now[DMABC_TIM_E_RD]));
   assign wr_n_o = !(state_reg == ST_WRITE && win(1'b0, var_md && tim_now[DMABC_TIM_E_WR]));
   assign memory_request_strobe_n_o = !(!io_now && win(1'b0, var_md && tim_now[DMABC_TIM_E_MEMORY_REQUEST_STROBE]));
   assign io_request_strobe_n_o =
      !(io_now && win(var_md, var_md && tim_now[DMABC_TIM_E_IO_REQUEST_STROBE]));
   assign addr_o = (rd_st == a_to_b) ? cur_a_reg : cur_b_reg;
   assign bus_oe_o = owner;
   assign data_oe_o = (state_reg == ST_WRITE);
   assign bus_request_out_n_o = 1'b0;
   assign bus_request_out_oe_o = req_reg;
   assign bus_ack_chain_out_n_o = bus_ack_in_n_i || req_reg;
   assign int_n_o = !(int_pend_reg && inactive);

   // Default timing latches at the falling edge of the last state; variable timing latches
   // where the read strobe rises, which is earlier when that strobe ends early.
   assign cap = rd_st && last_t && ce_i &&
      ((!tph_reg && (!var_md || tim_now[DMABC_TIM_E_RD])) ||
       (var_md && !tim_now[DMABC_TIM_E_RD] && tph_reg && !stretch_reg));

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         data_o <= 8'h00;
      end else if (cap) begin
         data_o <= data_i;
      end
   end

   assign cmd = reg_wdata_i[7:0];
   assign wr_cmd = reg_wr_i && (reg_addr_i == DMABC_OFS_COMMAND_WRITE_REG);
   assign cfg_wr = reg_wr_i && inactive;
   assign go_cmd = wr_cmd && (cmd == DMABC_CMD_ENABLE) && !arm_reg;
   assign go_return_from_interrupt = return_from_interrupt_i && arm_reg && en_pend_reg;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ctrl_reg <= DMABC_CTRL_RST;
         tim_a_reg <= DMABC_TIM_RST;
         tim_b_reg <= DMABC_TIM_RST;
         addr_a_reg <= DMABC_ADDR_RST;
         addr_b_reg <= DMABC_ADDR_RST;
         blen_reg <= DMABC_BLEN_RST;
         match_byte_reg <= DMABC_MATCH_RST;
      end else if (ce_i && cfg_wr) begin
         case (reg_addr_i)
            DMABC_OFS_CTRL: ctrl_reg <= reg_wdata_i;
            DMABC_OFS_TIM_A: tim_a_reg <= reg_wdata_i;
            DMABC_OFS_TIM_B: tim_b_reg <= reg_wdata_i;
            DMABC_OFS_ADDR_A: addr_a_reg <= reg_wdata_i;
            DMABC_OFS_ADDR_B: addr_b_reg <= reg_wdata_i;
            DMABC_OFS_BLEN: blen_reg <= reg_wdata_i;
            DMABC_OFS_MATCH: match_byte_reg <= reg_wdata_i[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (ce_i) begin
         reg_rdata_o <= 16'h0000;
         if (reg_rd_i) begin
            case (reg_addr_i)
               DMABC_OFS_CTRL: reg_rdata_o <= ctrl_reg;
               DMABC_OFS_TIM_A: reg_rdata_o <= tim_a_reg;
               DMABC_OFS_TIM_B: reg_rdata_o <= tim_b_reg;
               DMABC_OFS_ADDR_A: reg_rdata_o <= cur_a_reg;
               DMABC_OFS_ADDR_B: reg_rdata_o <= cur_b_reg;
               DMABC_OFS_BLEN: reg_rdata_o <= blen_reg;
               DMABC_OFS_MATCH: reg_rdata_o <= {8'h00, match_byte_reg};
               DMABC_OFS_COUNT: reg_rdata_o <= count_reg;
               DMABC_OFS_STATUS: begin
                  reg_rdata_o[DMABC_STS_OWNER] <= !inactive;
                  reg_rdata_o[DMABC_STS_MATCH] <= match_reg;
                  reg_rdata_o[DMABC_STS_EOB] <= eob_reg;
                  reg_rdata_o[DMABC_STS_INT] <= int_pend_reg;
               end
               default: ;
            endcase
         end
      end
   end

   // Interrupt latches: the return clears, a new event in the same cycle wins.
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         int_pend_reg <= 1'b0;
         arm_reg <= 1'b0;
         en_pend_reg <= 1'b0;
      end else if (ce_i) begin
         if (return_from_interrupt_i) begin
            int_pend_reg <= 1'b0;
         end
         if (go_return_from_interrupt) begin
            arm_reg <= 1'b0;
            en_pend_reg <= 1'b0;
         end
         if (wr_cmd && cmd == DMABC_CMD_EN_AFTER_RETURN_FROM_INTERRUPT) begin
            arm_reg <= 1'b1;
         end
         if (wr_cmd && cmd == DMABC_CMD_ENABLE && arm_reg) begin
            en_pend_reg <= 1'b1;
         end
         if (state_reg == ST_WAIT_RDY && tick && rdy_s_reg && ctrl_reg[DMABC_CTRL_INT_RDY]) begin
            int_pend_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         match_reg <= 1'b0;
         match_old_reg <= 1'b0;
      end else if (ce_i) begin
         if (wr_cmd && cmd == DMABC_CMD_LOAD) begin
            match_reg <= 1'b0;
            match_old_reg <= 1'b0;
         end
         if (byte_end) begin
            match_old_reg <= match_reg;
         end
         if (cap && op_srch && data_i == match_byte_reg) begin
            match_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rdy_s_reg <= 1'b0;
         bai_cnt_reg <= 2'h0;
      end else if (tick) begin
         rdy_s_reg <= rdy_act;
         if (state_reg != ST_ACK || bus_ack_in_n_i) begin
            bai_cnt_reg <= 2'h0;
         end else if (bai_cnt_reg != DMABC_BAI_LOW_EDGES) begin
            bai_cnt_reg <= bai_cnt_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_OFF;
         req_reg <= 1'b0;
         eob_reg <= 1'b0;
         count_reg <= 16'h0000;
         cur_a_reg <= DMABC_ADDR_RST;
         cur_b_reg <= DMABC_ADDR_RST;
      end else if (ce_i) begin
         case (state_reg)
            ST_OFF: begin
               if (go_cmd || go_return_from_interrupt) begin
                  state_reg <= ST_WAIT_RDY;
                  eob_reg <= 1'b0;
               end
            end
            ST_WAIT_RDY: begin
               if (tick && rdy_s_reg) begin
                  if (ctrl_reg[DMABC_CTRL_INT_RDY]) begin
                     state_reg <= ST_OFF;
                  end else if (bus_request_in_n_i) begin
                     req_reg <= 1'b1;
                     state_reg <= ST_ACK;
                  end
               end
            end
            ST_ACK: begin
               if (tick && bai_cnt_reg == DMABC_BAI_LOW_EDGES) begin
                  state_reg <= ST_READ;
               end
            end
            ST_READ: begin
               if (cyc_end && op_xfer) begin
                  state_reg <= ST_WRITE;
               end
            end
            ST_WRITE: ;
            ST_IDLE_RDY: begin
               if (tick && rdy_s_reg) begin
                  state_reg <= ST_READ;
               end
            end
            ST_REL: begin
               if (tick) begin
                  req_reg <= 1'b0;
                  if (!req_reg && bus_ack_in_n_i) begin
                     state_reg <= ST_WAIT_RDY;
                  end
               end
            end
            default: state_reg <= ST_OFF;
         endcase
         // The host sees the release one state early; it cannot start before the cycle ends.
         if (cyc_act && final_cyc && byte_md && tick && !stretch_reg &&
             t_reg == cyc_len - 3'h1) begin
            req_reg <= 1'b0;
         end
         if (byte_end) begin
            count_reg <= count_reg + 16'h0001;
            if (ctrl_reg[DMABC_CTRL_A_INC]) begin
               cur_a_reg <= cur_a_reg + 16'h0001;
            end
            if (ctrl_reg[DMABC_CTRL_B_INC]) begin
               cur_b_reg <= cur_b_reg + 16'h0001;
            end
            if (last_byte || stop_now) begin
               state_reg <= ST_OFF;
               req_reg <= 1'b0;
               eob_reg <= last_byte;
            end else if (byte_md) begin
               state_reg <= ST_REL;
            end else if (!rdy_s_reg) begin
               state_reg <= (mode == DMABC_MODE_CONT) ? ST_IDLE_RDY : ST_REL;
            end else begin
               state_reg <= ST_READ;
            end
         end
         if (wr_cmd && cmd == DMABC_CMD_LOAD && inactive) begin
            count_reg <= 16'h0000;
            cur_a_reg <= addr_a_reg;
            cur_b_reg <= addr_b_reg;
         end
         if (wr_cmd && cmd == DMABC_CMD_DISABLE) begin
            state_reg <= ST_OFF;
            req_reg <= 1'b0;
         end
      end
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   sequence seq_ack_seen;
      tick && state_reg == ST_ACK && bai_cnt_reg == DMABC_BAI_LOW_EDGES && !reg_wr_i;
   endsequence
   sequence seq_rdy_free;
      tick && state_reg == ST_WAIT_RDY && rdy_s_reg && bus_request_in_n_i && !reg_wr_i;
   endsequence

   chk_ack_then_xfer: assert property (seq_ack_seen |=> state_reg == ST_READ)
      else $error("transfer did not start after two acknowledge samples");
   chk_req_on_ready: assert property (seq_rdy_free and !ctrl_reg[DMABC_CTRL_INT_RDY]
      |=> bus_request_out_oe_o ##0 state_reg == ST_ACK)
      else $error("bus request missing after ready");
   chk_rdy_int_noreq: assert property (seq_rdy_free and ctrl_reg[DMABC_CTRL_INT_RDY]
      |=> !bus_request_out_oe_o && state_reg == ST_OFF)
      else $error("interrupt on ready drove bus request");
   chk_default_len: assert property (cyc_act && !var_md |->
      cyc_len == (io_now ? DMABC_DEF_IO_LEN : DMABC_DEF_MEM_LEN))
      else $error("default cycle length wrong");
   chk_io_request_strobe_leads: assert property (cyc_act && var_md && io_now && t_reg == 3'h1 && !tph_reg
      |-> !io_request_strobe_n_o && rd_n_o && wr_n_o)
      else $error("io strobe does not lead in variable mode");
   chk_rd_early_end: assert property (rd_st && var_md && tim_now[DMABC_TIM_E_RD] && last_t
      && tph_reg && !stretch_reg |-> rd_n_o)
      else $error("read strobe did not end early");
   chk_wait_stretch: assert property (cyc_act && stretch_reg && tick && !reg_wr_i
      |=> $stable(t_reg))
      else $error("wait did not hold the state");
   chk_data_held: assert property (state_reg == ST_WRITE && $past(state_reg) == ST_WRITE
      |-> $stable(data_o) && data_oe_o)
      else $error("read data not held through write");
   chk_int_inactive: assert property (!int_n_o |-> inactive)
      else $error("interrupt asserted while mastering");
   chk_byte_release: assert property (byte_end && byte_md |-> !bus_request_out_oe_o)
      else $error("byte mode request not dropped before cycle end");
   chk_cont_keeps: assert property (state_reg == ST_IDLE_RDY |-> bus_request_out_oe_o)
      else $error("continuous mode released bus while not ready");
endmodule
`default_nettype wire

// file: bench/dmabc_host_model.sv
// Host-side bus model: grants the bus after two clock cycles and answers read strobes.
`timescale 1ns/100ps
`default_nettype none
module dmabc_host_model (
   input wire logic clk_sys_i,
   input wire logic req_wire_n_i,
   input wire logic rd_n_i,
   input wire logic [15:0] addr_i,
   output logic [7:0] data_o,
   output logic ack_n_o
);
   logic [1:0] ack_dly_reg = 2'b11;
   logic [7:0] last_reg = 8'h00;
   always_ff @(posedge clk_sys_i) begin
      ack_dly_reg <= {ack_dly_reg[0], req_wire_n_i};
      if (!rd_n_i) begin
         last_reg <= data_o;
      end
   end
   // A released bus shows the inverse of the last byte, so stale data cannot pass.
   assign data_o = !rd_n_i ? (addr_i[7:0] ^ 8'h5A) : ~last_reg;
   // Grant drops as soon as the request is withdrawn.
   assign ack_n_o = ack_dly_reg[1] | req_wire_n_i;
endmodule
`default_nettype wire

// file: bench/test_dmabc_top.sv
// Self-checking bench for the DMA bus-cycle engine.
`timescale 1ns/100ps
`default_nettype none
module test_dmabc_top;
   import dmabc_pkg::*;
   logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, addr_o, v;
   logic [7:0] data_i, data_o, cap;
   logic data_oe_o, bus_oe_o, memory_request_strobe_n_o, io_request_strobe_n_o, rd_n_o, wr_n_o;
   logic ready_i = 1'b0, wait_n_i = 1'b1, bus_request_out_n_o, bus_request_out_oe_o;
   logic bus_request_in_n_i, bus_ack_in_n_i, bus_ack_chain_out_n_o, int_n_o;
   logic return_from_interrupt_i = 1'b0;
   int err_count = 0, total_checks = 0, cycles = 0, n_rd, n_oe, n_io, n_mr;
   always #5 clk_sys_i = ~clk_sys_i;
   // Open-drain request line: only this block pulls it low.
   assign bus_request_in_n_i = bus_request_out_oe_o ? bus_request_out_n_o : 1'b1;
   dmabc_top dut (.clk_sys_i, .sys_rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .addr_o, .data_i, .data_o, .data_oe_o, .bus_oe_o,
      .memory_request_strobe_n_o, .io_request_strobe_n_o, .rd_n_o, .wr_n_o, .ready_i,
      .wait_n_i, .bus_request_out_n_o, .bus_request_out_oe_o, .bus_request_in_n_i,
      .bus_ack_in_n_i, .bus_ack_chain_out_n_o, .return_from_interrupt_i, .int_n_o);
   dmabc_host_model host (.clk_sys_i(clk_sys_i), .req_wire_n_i(bus_request_in_n_i),
      .rd_n_i(rd_n_o), .addr_i(addr_o), .data_o(data_i), .ack_n_o(bus_ack_in_n_i));
   task automatic end_of_test;
      $display("Checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
      @(posedge clk_sys_i);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask
   // Programs a block and starts it; ready is raised once the block is enabled.
   task automatic start(input logic [15:0] ctrl, input logic [15:0] blen);
      wr(DMABC_OFS_ADDR_A, 16'h1050);
      wr(DMABC_OFS_ADDR_B, 16'h0005);
      wr(DMABC_OFS_BLEN, blen);
      wr(DMABC_OFS_CTRL, ctrl);
      wr(DMABC_OFS_COMMAND_WRITE_REG, {8'h00, DMABC_CMD_LOAD});
      wr(DMABC_OFS_COMMAND_WRITE_REG, {8'h00, DMABC_CMD_ENABLE});
      ready_i <= 1'b1;
   endtask
   initial begin
      cyc(5);
      sys_rst_i <= 1'b0;
      rd(DMABC_OFS_CTRL, v);
      check("ctrl_reset", DMABC_CTRL_RST, v);
      #1 check("rdata_idle", 16'h0000, reg_rdata_o);
      rd(DMABC_OFS_TIM_A, v);
      check("tim_reset", DMABC_TIM_RST, v);
      rd(4'hF, v);
      check("unmapped", 16'h0000, v);
      // Single byte, memory port A to I/O port B, default then variable timing.
      // Variable read port: two states, read strobe ends early; write port four states.
      wr(DMABC_OFS_TIM_A, 16'h0022);
      wr(DMABC_OFS_TIM_B, 16'h0004);
      for (int vm = 0; vm < 2; vm++) begin
         start(16'h0D46 | 16'(vm << 4), 16'h0000);
         n_rd = 0;
         n_oe = 0;
         n_io = 0;
         n_mr = 0;
         repeat (120) begin
            @(posedge clk_sys_i);
            #1 n_rd += (rd_n_o === 1'b0);
            n_oe += (data_oe_o === 1'b1);
            n_io += (io_request_strobe_n_o === 1'b0);
            n_mr += (memory_request_strobe_n_o === 1'b0);
            if (data_oe_o === 1'b1) cap = data_o;
         end
         check("read_cycles", vm ? 16'h0002 : 16'h0005, 16'(n_rd));
         check("mem_cycles", vm ? 16'h0003 : 16'h0005, 16'(n_mr));
         check("write_cycles", 16'h0008, 16'(n_oe));
         check("io_cycles", vm ? 16'h0008 : 16'h0007, 16'(n_io));
         check("captured", 16'h000A, {8'h00, cap});
         check("req_end", 16'h0000, {15'h0, bus_request_out_oe_o});
         rd(DMABC_OFS_STATUS, v);
         check("status_eob", 16'h0004, v & 16'h0005);
      end
      // Ready withdrawn mid-block: continuous keeps the bus, byte and burst let it go.
      for (int m = 0; m <= 2; m++) begin
         ready_i <= 1'b0;
         start(16'h0D44 | 16'(m), 16'h0003);
         for (int i = 0; i < 100 && bus_request_out_oe_o !== 1'b1; i++) cyc(1);
         check("req_raised", 16'h0001, {15'h0, bus_request_out_oe_o});
         cyc(10);
         ready_i <= 1'b0;
         cyc(40);
         check("req_not_ready", 16'(m == 1), {15'h0, bus_request_out_oe_o});
         ready_i <= 1'b1;
         cyc(200);
         check("req_done", 16'h0000, {15'h0, bus_request_out_oe_o});
      end
      // Stop on match in a burst transfer: the second byte matches and is the last written.
      wr(DMABC_OFS_MATCH, 16'h000B);
      start(16'h0DE6, 16'h0007);
      cyc(150);
      rd(DMABC_OFS_COUNT, v);
      check("match_count", 16'h0002, v);
      rd(DMABC_OFS_STATUS, v);
      check("match_status", 16'h0002, v & 16'h0003);
      // An I/O read is held in its inserted wait state while the wait input stays low.
      wait_n_i <= 1'b0;
      start(16'h0B4E, 16'h0000);
      cyc(40);
      check("wait_rd", 16'h0000, {15'h0, rd_n_o});
      check("wait_io", 16'h0000, {15'h0, io_request_strobe_n_o});
      check("wait_owner", 16'h0001, {15'h0, bus_oe_o});
      wait_n_i <= 1'b1;
      cyc(60);
      check("wait_done", 16'h0000, {15'h0, bus_request_out_oe_o});
      // Interrupt on ready raises the interrupt and never requests the bus.
      ready_i <= 1'b0;
      wr(DMABC_OFS_CTRL, 16'h2004);
      wr(DMABC_OFS_COMMAND_WRITE_REG, {8'h00, DMABC_CMD_ENABLE});
      ready_i <= 1'b1;
      cyc(10);
      check("int_on_ready", 16'h0000, {15'h0, int_n_o});
      check("no_request", 16'h0000, {15'h0, bus_request_out_oe_o});
      // Re-enable: arm, enable, and only the return pulse starts the block.
      wr(DMABC_OFS_CTRL, 16'h0D46);
      wr(DMABC_OFS_COMMAND_WRITE_REG, {8'h00, DMABC_CMD_LOAD});
      wr(DMABC_OFS_COMMAND_WRITE_REG, {8'h00, DMABC_CMD_EN_AFTER_RETURN_FROM_INTERRUPT});
      wr(DMABC_OFS_COMMAND_WRITE_REG, {8'h00, DMABC_CMD_ENABLE});
      cyc(10);
      check("armed_idle", 16'h0000, {15'h0, bus_request_out_oe_o});
      return_from_interrupt_i <= 1'b1;
      cyc(1);
      return_from_interrupt_i <= 1'b0;
      cyc(100);
      rd(DMABC_OFS_STATUS, v);
      check("return_from_interrupt_block", 16'h0004, v & 16'h000D);
      end_of_test();
   end
endmodule
`default_nettype wire
